/* File: rtl/mode_word_block.sv */
/*
 * mode word capture and burst ordering of a double data rate memory
 * device. command pins are decoded on the link clock ck; the stored
 * words cross to the system clock by a request/acknowledge handshake
 * and are decoded into registered option outputs there.
 * assumes ck runs free while the block is in use and that the
 * controller keeps its own timing between commands.
 */
// Contract
// - command and bank lines low writes main word
// - option writes never touch stored array data
// - bits 2..0: 010 four beats, 011 eight
// - bit 3 picks sequential or interleaved order
// - bits 6..4 give read latency 3 to 7
// - only whole clock read latencies exist
// - bit 8 set requests loop reset
// - bits 11..9 give recovery of 2 to 8
// - bit 12 picks fast or slow exit
// - recovery plus precharge sets auto-precharge gap
// - bit 14 used only on narrow organisation
// - sequential order wraps low bits per nibble
// - interleaved order is index xor start column
// - back to back bursts flow without gap
// - no burst stop command exists or decodes
// - bank 001 with same pattern writes extended word
`timescale 1ns/1ps
module mode_word_block (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        ck,
    input  wire logic        cke,
    input  wire logic        cs_n,
    input  wire logic        ras_n,
    input  wire logic        cas_n,
    input  wire logic        we_n,
    input  wire logic [2:0]  ba,
    input  wire logic [14:0] addr,
    input  wire logic        org_x16,
    output logic             mode_programmed,
    output logic             burst_len8,
    output logic             burst_interleave,
    output logic      [2:0]  read_latency,
    output logic      [3:0]  recovery_clocks,
    output logic      [4:0]  autoprecharge_store_gap,
    output logic             slow_exit,
    output logic             reserved_code_error,
    output logic             dll_reset_pulse,
    output logic      [14:0] ext1_option_word,
    output logic      [2:0]  column_index,
    output logic             column_valid
);

    // link clock domain

    mode_word_pkg::cmd_pins_t pins;
    mode_word_pkg::mode_xfer_t xfer;
    logic [14:0] main_operating_mode_word;
    logic [14:0] first_extended_option_word;
    logic        link_reset;
    logic        org_x16_link;
    logic        dirty;
    logic        main_dirty;
    logic        dll_pending;
    logic        xfer_req;
    logic        ack_seen_link;

    // pin bundle; these pins live on ck already, so no synchroniser
    assign pins.cke   = cke;
    assign pins.cs_n  = cs_n;
    assign pins.ras_n = ras_n;
    assign pins.cas_n = cas_n;
    assign pins.we_n  = we_n;
    assign pins.ba    = ba;
    assign pins.addr  = addr;

    // reset and strap brought over to ck
    pin_sync3 #(
        .WIDTH(2)
    ) u_link_sync (
        .clk (ck),
        .d   ({reset, org_x16}),
        .q   ({link_reset, org_x16_link})
    );

    // command decode; the burst stop pattern has no decode at all
    wire cmd_low      = pins.cke && !pins.cs_n && !pins.ras_n && !pins.cas_n;
    wire mode_set_command     = cmd_low && !pins.we_n
                                && (pins.ba == mode_word_pkg::BANK_MAIN_WORD);
    wire extended_set_command = cmd_low && !pins.we_n
                                && (pins.ba == mode_word_pkg::BANK_EXT1_WORD);
    wire column_command = pins.cke && !pins.cs_n && pins.ras_n && !pins.cas_n;

    // the top row bit only counts on the wide-row organisation
    wire [14:0] row_word = {pins.addr[mode_word_pkg::ORG_TOP_BIT] && !org_x16_link,
                            pins.addr[13:0]};

    // handshake state on the link side
    wire busy      = xfer_req != ack_seen_link;
    wire launch    = dirty && !busy;
    wire req_dll   = mode_set_command && row_word[mode_word_pkg::DLL_RESET_BIT];

    // words kept as plain registers, away from any array path
    always_ff @(posedge ck) begin
        if (link_reset) begin
            main_operating_mode_word   <= mode_word_pkg::WORD_RESET;
            first_extended_option_word <= mode_word_pkg::WORD_RESET;
        end else begin
            if (mode_set_command) begin
                main_operating_mode_word <= row_word;
            end
            if (extended_set_command) begin
                first_extended_option_word <= row_word;
            end
        end
    end

    // launch a snapshot whenever a write is waiting and the path is free;
    // a write landing in the launch cycle keeps its flag set
    always_ff @(posedge ck) begin
        if (link_reset) begin
            dirty       <= 1'b0;
            main_dirty  <= 1'b0;
            dll_pending <= 1'b0;
            xfer_req    <= 1'b0;
            xfer        <= '0;
        end else begin
            dirty       <= (dirty && !launch) || mode_set_command || extended_set_command;
            main_dirty  <= (main_dirty && !launch) || mode_set_command;
            dll_pending <= (dll_pending && !launch) || req_dll;
            if (launch) begin
                xfer_req          <= !xfer_req;
                xfer.main_word    <= main_operating_mode_word;
                xfer.ext1_word    <= first_extended_option_word;
                xfer.main_written <= main_dirty;
                xfer.dll_reset    <= dll_pending;
            end
        end
    end

    // column ordering follows the word currently held on ck
    wire [2:0] count_code = main_operating_mode_word[mode_word_pkg::BURST_COUNT_LSB +: 3];

    burst_order_gen u_burst (
        .ck         (ck),
        .link_reset (link_reset),
        .start      (column_command),
        .start_col  (pins.addr[2:0]),
        .len8       (count_code == mode_word_pkg::BURST_COUNT_8),
        .interleave (main_operating_mode_word[mode_word_pkg::BURST_ORDER_BIT]),
        .col        (column_index),
        .col_valid  (column_valid)
    );

    // system clock domain

    logic        req_sync;
    logic        ack;

    pin_sync3 #(
        .WIDTH(1)
    ) u_req_sync (
        .clk (clk),
        .d   (xfer_req),
        .q   (req_sync)
    );

    pin_sync3 #(
        .WIDTH(1)
    ) u_ack_sync (
        .clk (ck),
        .d   (ack),
        .q   (ack_seen_link)
    );

    // snapshot is held still by the link side until ack returns
    wire        capture   = req_sync != ack;
    wire [14:0] new_word  = xfer.main_word;
    wire [2:0]  new_count = new_word[mode_word_pkg::BURST_COUNT_LSB +: 3];
    wire [2:0]  new_lat   = new_word[mode_word_pkg::LATENCY_LSB +: 3];
    wire [2:0]  new_rec   = new_word[mode_word_pkg::RECOVERY_LSB +: 3];

    // reserved codes: burst count, latency, test bit, recovery
    wire bad_count = (new_count != mode_word_pkg::BURST_COUNT_4)
                     && (new_count != mode_word_pkg::BURST_COUNT_8);
    wire bad_lat   = new_lat < mode_word_pkg::LATENCY_MIN_CODE;
    wire bad_test  = new_word[mode_word_pkg::TEST_BIT];
    wire bad_rec   = new_rec == mode_word_pkg::RECOVERY_RSVD;
    wire new_bad   = bad_count || bad_lat || bad_test || bad_rec;

    // codes 3..7 equal the latency, so the code itself is the count;
    // there is no half clock setting to widen the field for
    wire [2:0] new_latency  = bad_lat ? 3'h0 : new_lat;
    wire [3:0] new_recovery = 4'({1'b0, new_rec} + 4'h1);
    wire [4:0] new_gap      = 5'({1'b0, new_recovery}
                              + 5'(mode_word_pkg::PRECHARGE_CYCLES));

    // decoded option registers; refreshed only by a main word write, ext1_option_word by every capture
    always_ff @(posedge clk) begin
        if (reset) begin
            ack                     <= 1'b0;
            mode_programmed         <= 1'b0;
            burst_len8              <= 1'b0;
            burst_interleave        <= 1'b0;
            read_latency            <= 3'h0;
            recovery_clocks         <= 4'h0;
            autoprecharge_store_gap <= 5'h00;
            slow_exit               <= 1'b0;
            reserved_code_error     <= 1'b0;
            dll_reset_pulse         <= 1'b0;
            ext1_option_word        <= mode_word_pkg::WORD_RESET;
        end else begin
            dll_reset_pulse <= capture && xfer.dll_reset;
            if (capture) begin
                ack              <= req_sync;
                ext1_option_word <= xfer.ext1_word;
            end
            if (capture && xfer.main_written) begin
                mode_programmed         <= 1'b1;
                burst_len8              <= new_count == mode_word_pkg::BURST_COUNT_8;
                burst_interleave        <= new_word[mode_word_pkg::BURST_ORDER_BIT];
                read_latency            <= new_latency;
                recovery_clocks         <= new_recovery;
                autoprecharge_store_gap <= new_gap;
                slow_exit               <= new_word[mode_word_pkg::EXIT_SPEED_BIT];
                reserved_code_error     <= new_bad;
            end
        end
    end

endmodule : mode_word_block

/* File: common/mode_word_pkg.sv */
/*
 * shared constants and carriers for the mode word block: command pin
 * bundle, field positions of the main option word,
 * field codes and the precharge period used for the auto-precharge gap.
 * assumes every user names items as mode_word_pkg::name.
 */
package mode_word_pkg;

    // word geometry
    localparam int             WORD_W           = 15;
    localparam logic [14:0]    WORD_RESET       = 15'h0000;
    localparam int             ORG_TOP_BIT      = 14;

    // main option word fields
    localparam int             BURST_COUNT_LSB  = 0;
    localparam int             BURST_ORDER_BIT  = 3;
    localparam int             LATENCY_LSB      = 4;
    localparam int             TEST_BIT         = 7;
    localparam int             DLL_RESET_BIT    = 8;
    localparam int             RECOVERY_LSB     = 9;
    localparam int             EXIT_SPEED_BIT   = 12;

    // field codes
    localparam logic [2:0]     BURST_COUNT_4    = 3'h2;
    localparam logic [2:0]     BURST_COUNT_8    = 3'h3;
    localparam logic [2:0]     LATENCY_MIN_CODE = 3'h3;
    localparam logic [2:0]     RECOVERY_RSVD    = 3'h0;
    localparam logic [2:0]     BANK_MAIN_WORD   = 3'h0;
    localparam logic [2:0]     BANK_EXT1_WORD   = 3'h1;
    localparam logic [2:0]     LAST_BEAT_4      = 3'h3;
    localparam logic [2:0]     LAST_BEAT_8      = 3'h7;

    // precharge period in ns and its count at the 40 ns system clock
    localparam int             PRECHARGE_NS     = 15;
    localparam int             CLK_PERIOD_NS    = 40;
    localparam int             PRECHARGE_CYCLES =
        (PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // command pins as sampled on the link clock
    typedef struct packed {
        logic        cke;
        logic        cs_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic [2:0]  ba;
        logic [14:0] addr;
    } cmd_pins_t;

    // words handed from the link domain to the system domain
    typedef struct packed {
        logic [14:0] main_word;
        logic [14:0] ext1_word;
        logic        main_written;
        logic        dll_reset;
    } mode_xfer_t;

endpackage : mode_word_pkg

/* File: rtl/pin_sync3.sv */
/*
 * three-stage synchroniser, one chain per bit; the output moves only
 * once the second and third stages agree.
 * assumes d comes from another clock domain or a pin.
 */
`timescale 1ns/1ps
module pin_sync3 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic s1;
            logic s2;
            logic s3;
            // s1 is read by s2 only, to keep metastability contained
            always_ff @(posedge clk) begin
                s1 <= d[i];
                s2 <= s1;
                s3 <= s2;
                if (s2 == s3) begin
                    q[i] <= s3;
                end
            end
        end
    endgenerate
endmodule : pin_sync3

/* File: rtl/burst_order_gen.sv */
/*
 * column order generator for one burst, one column index per link
 * clock; a new start restarts the sequence at once.
 * assumes start is a one-cycle pulse on the link clock.
 */
`timescale 1ns/1ps
module burst_order_gen (
    input  wire logic       ck,
    input  wire logic       link_reset,
    input  wire logic       start,
    input  wire logic [2:0] start_col,
    input  wire logic       len8,
    input  wire logic       interleave,
    output logic      [2:0] col,
    output logic            col_valid
);
    logic [2:0] idx;
    logic [2:0] base;
    logic       active;

    wire  [2:0] last_beat   = len8 ? mode_word_pkg::LAST_BEAT_8 : mode_word_pkg::LAST_BEAT_4;
    wire        step        = active && (idx != last_beat);
    wire  [2:0] next_idx    = start ? 3'h0 : 3'(idx + 3'h1);
    wire  [2:0] next_base   = start ? start_col : base;
    wire        next_active = start || step;
    // sequential wraps the low pair inside the nibble, then flips nibble
    wire  [1:0] seq_low     = 2'(next_base[1:0] + next_idx[1:0]);
    wire  [2:0] seq_col     = {next_base[2] ^ next_idx[2], seq_low};
    // idx never passes 3 for four beats, so the top bit stays put
    wire  [2:0] ilv_col     = next_base ^ next_idx;
    wire  [2:0] next_col    = interleave ? ilv_col : seq_col;

    // a start mid-burst or on the last beat continues without a gap
    always_ff @(posedge ck) begin
        if (link_reset) begin
            idx       <= 3'h0;
            base      <= 3'h0;
            active    <= 1'b0;
            col       <= 3'h0;
            col_valid <= 1'b0;
        end else begin
            idx       <= next_idx;
            base      <= next_base;
            active    <= next_active;
            col       <= next_col;
            col_valid <= next_active;
        end
    end
endmodule : burst_order_gen

/* File: tb/mode_word_block_monitor.sv */
/* port checks for the mode word block: burst beats on ck, option outputs on clk.
   assumes it is bound to mode_word_block and sees only its ports. */
`timescale 1ns/1ps
module mode_word_block_monitor (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        ck,
    input wire logic        cke,
    input wire logic        cs_n,
    input wire logic        ras_n,
    input wire logic        cas_n,
    input wire logic [14:0] addr,
    input wire logic        mode_programmed,
    input wire logic [2:0]  read_latency,
    input wire logic [3:0]  recovery_clocks,
    input wire logic [4:0]  autoprecharge_store_gap,
    input wire logic        reserved_code_error,
    input wire logic        dll_reset_pulse,
    input wire logic [2:0]  column_index,
    input wire logic        column_valid
);
    logic [3:0] beat_n;
    wire        col_cmd   = cke && !cs_n && ras_n && !cas_n;
    wire  [2:0] start_col = addr[2:0];

    // beats since the last column command; saturates so a stuck valid still shows
    always_ff @(posedge ck) begin
        if (reset || col_cmd) beat_n <= 4'h0;
        else if (column_valid && beat_n != 4'hf) beat_n <= beat_n + 4'h1;
    end

    AST_FIRST_BEAT: assert property (@(posedge ck) disable iff (reset)
        col_cmd |=> column_valid && column_index == $past(start_col))
        else $error("first beat not at start column");
    AST_MIN_BEATS: assert property (@(posedge ck) disable iff (reset)
        col_cmd |=> column_valid [*4])
        else $error("burst shorter than four beats");
    AST_MAX_BEATS: assert property (@(posedge ck) disable iff (reset)
        column_valid |-> beat_n <= 4'h7)
        else $error("burst longer than eight beats");
    AST_IDLE: assert property (@(posedge ck) disable iff (reset)
        !column_valid && !col_cmd |=> !column_valid)
        else $error("beat without column command");
    AST_LAT_RANGE: assert property (@(posedge clk) disable iff (reset)
        mode_programmed |-> read_latency inside {3'h0, [3'h3:3'h7]})
        else $error("latency out of range");
    AST_REC_RANGE: assert property (@(posedge clk) disable iff (reset)
        mode_programmed |-> recovery_clocks inside {[4'h1:4'h8]})
        else $error("recovery out of range");
    AST_GAP: assert property (@(posedge clk) disable iff (reset)
        mode_programmed |->
        autoprecharge_store_gap == 5'(recovery_clocks) + 5'(mode_word_pkg::PRECHARGE_CYCLES))
        else $error("auto-precharge gap wrong");
    AST_DLL_PULSE: assert property (@(posedge clk) disable iff (reset)
        dll_reset_pulse |=> !dll_reset_pulse)
        else $error("loop reset pulse too long");
    AST_PROG_HOLD: assert property (@(posedge clk) disable iff (reset)
        mode_programmed |=> mode_programmed)
        else $error("programmed flag dropped");
endmodule : mode_word_block_monitor

bind mode_word_block mode_word_block_monitor mon_u (.clk(clk), .reset(reset), .ck(ck),
    .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .addr(addr),
    .mode_programmed(mode_programmed), .read_latency(read_latency),
    .recovery_clocks(recovery_clocks), .autoprecharge_store_gap(autoprecharge_store_gap),
    .reserved_code_error(reserved_code_error), .dll_reset_pulse(dll_reset_pulse),
    .column_index(column_index), .column_valid(column_valid));

/* File: tb/ctrl_cmd_model.sv */
/* behavioural memory controller driving the command pins on ck.
   assumes callers enter its tasks just after a rising ck edge. */
`timescale 1ns/1ps
module ctrl_cmd_model #(
    parameter int MODE_SET_GAP = 2,
    parameter int DLL_WAIT     = 200
) (
    input  wire logic               ck,
    output mode_word_pkg::cmd_pins_t pins
);
    int since_dll = 0;

    // clocks since the last loop reset request
    always @(posedge ck) since_dll = since_dll + 1;

    initial pins = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 3'h0, 15'h0000};

    // one command for one ck cycle; then cke and cs_n go high, bank and address show the inverse, ras_n, cas_n and we_n keep their value
    task automatic issue(input logic [3:0] ctl, input logic [2:0] ba, input logic [14:0] a,
                         input logic en);
        pins = '{en, ctl[3], ctl[2], ctl[1], ctl[0], ba, a};
        @(posedge ck);
        #1;
        pins.cke = 1'b1;
        pins.cs_n = 1'b1;
        pins.ba = ~ba;
        pins.addr = ~a;
    endtask : issue

    // whole option word, then the set gap before anything else
    task automatic set_word(input logic [2:0] ba, input logic [14:0] a, input logic en);
        issue(4'h0, ba, a, en);
        if (en && ba == 3'h0 && a[8]) since_dll = 0;
        repeat (MODE_SET_GAP) @(posedge ck);
        #1;
    endtask : set_word

    // read command; held back while the loop is still locking
    task automatic column(input logic [2:0] s);
        while (since_dll < DLL_WAIT) begin
            @(posedge ck);
            #1;
        end
        issue(4'h5, 3'h0, {12'h000, s}, 1'b1);
    endtask : column

    // recovery code from a time in ns: whole clocks rounded up, code is clocks less one
    function automatic logic [2:0] rec_code(input int ns, input int period);
        return 3'((ns + period - 1) / period - 1);
    endfunction : rec_code
endmodule : ctrl_cmd_model

/* File: tb/mode_word_block_tb.sv */
/* self-checking bench: option word writes, extended word, burst ordering.
   assumes the controller model drives all command pins. */
`timescale 1ns/1ps
module mode_word_block_tb;
    logic clk, reset, ck, org_x16, mode_programmed, burst_len8, burst_interleave;
    logic slow_exit, reserved_code_error, dll_reset_pulse, column_valid;
    logic [2:0] read_latency, column_index;
    logic [3:0] recovery_clocks;
    logic [4:0] autoprecharge_store_gap;
    logic [14:0] ext1_option_word;
    mode_word_pkg::cmd_pins_t pins;
    logic [14:0] rec_word;
    // assumed store recovery time; the period matches the bench link clock
    localparam int STORE_RECOVERY_NS = 100;
    localparam int CK_PERIOD_NS      = 32;
    localparam int REC_CLOCKS        = (STORE_RECOVERY_NS + CK_PERIOD_NS - 1) / CK_PERIOD_NS;
    int bad_count = 0, n_checks = 0, cyc = 0, dll_n = 0, exp_dll = 0;

    mode_word_block dut_u (.clk(clk), .reset(reset), .ck(ck), .cke(pins.cke),
        .cs_n(pins.cs_n), .ras_n(pins.ras_n), .cas_n(pins.cas_n), .we_n(pins.we_n),
        .ba(pins.ba), .addr(pins.addr), .org_x16(org_x16), .mode_programmed(mode_programmed),
        .burst_len8(burst_len8), .burst_interleave(burst_interleave),
        .read_latency(read_latency), .recovery_clocks(recovery_clocks),
        .autoprecharge_store_gap(autoprecharge_store_gap), .slow_exit(slow_exit),
        .reserved_code_error(reserved_code_error), .dll_reset_pulse(dll_reset_pulse),
        .ext1_option_word(ext1_option_word), .column_index(column_index),
        .column_valid(column_valid));
    ctrl_cmd_model ctrl_u (.ck(ck), .pins(pins));

    task automatic stop_test();
        if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // column low bits of beat i: nibble-wrapped count or xor with start
    function automatic logic [2:0] beat(logic [2:0] s, int i, logic l8, logic il);
        logic [2:0] j;
        j = 3'(i);
        if (il) return l8 ? s ^ j : {s[2], s[1:0] ^ j[1:0]};
        return {l8 ? s[2] ^ j[2] : s[2], s[1:0] + j[1:0]};
    endfunction : beat

    function automatic logic [14:0] mk(logic [2:0] k);
        return {2'b00, k[2], k, k[0], 1'b0, k, k[1], 2'b01, k[0]};
    endfunction : mk

    // one burst; unless last, returns on its final beat so the next follows seamlessly
    task automatic burst(input logic [2:0] s, input logic l8, input logic il, input logic last);
        int n;
        n = l8 ? 8 : 4;
        ctrl_u.column(s);
        for (int i = 0; i < n; i++) begin
            check("valid", column_valid, 1'b1);
            check("column", column_index, beat(s, i, l8, il));
            if (i < n - 1 || last) begin
                @(posedge ck);
                #1;
            end
        end
        if (last) check("end", column_valid, 1'b0);
    endtask : burst

    // option outputs after the crossing has settled
    task automatic expect_word(input logic [2:0] k, input logic err);
        repeat (20) @(posedge clk);
        #1;
        check("len8", burst_len8, k[0]);
        check("interleave", burst_interleave, k[1]);
        check("latency", read_latency, (k >= 3'h3) ? k : 3'h0);
        check("recovery", recovery_clocks, 4'(k) + 4'h1);
        check("gap", autoprecharge_store_gap,
              5'(k) + 5'h1 + 5'(mode_word_pkg::PRECHARGE_CYCLES));
        check("slow_exit", slow_exit, k[2]);
        check("reserved", reserved_code_error, err);
        check("dll", 16'(dll_n), 16'(exp_dll));
        check("programmed", mode_programmed, 1'b1);
    endtask : expect_word

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // link clock, unrelated phase
    initial begin
        ck = 1'b0;
        #7;
        forever #16 ck = ~ck;
    end
    // pulse count and hang guard; a full run needs about 1200 cycles
    always @(posedge clk) begin
        dll_n += (dll_reset_pulse === 1'b1);
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            stop_test();
        end
    end

    initial begin
        reset = 1'b1;
        org_x16 = 1'b0;
        repeat (16) @(posedge clk);
        #1 reset = 1'b0;
        repeat (8) @(posedge ck);
        #1;
        check("unprogrammed", mode_programmed, 1'b0);
        for (int k = 0; k < 8; k++) begin
            ctrl_u.set_word(3'h0, mk(3'(k)), 1'b1);
            exp_dll += k % 2;
            burst(3'(k * 3), k[0], k[1], 1'b0);
            burst(~3'(k * 3), k[0], k[1], 1'b1);
            expect_word(3'(k), k < 3);
        end
        ctrl_u.set_word(3'h0, mk(3'h7) | 15'h0080, 1'b1);
        exp_dll++;
        expect_word(3'h7, 1'b1);
        ctrl_u.set_word(3'h0, mk(3'h3), 1'b0);
        expect_word(3'h7, 1'b1);
        ctrl_u.issue(4'h6, 3'h0, 15'h0005, 1'b1);
        repeat (3) begin
            check("stop", column_valid, 1'b0);
            @(posedge ck);
            #1;
        end
        org_x16 = 1'b1;
        repeat (10) @(posedge ck);
        #1;
        ctrl_u.set_word(3'h1, 15'h7abc, 1'b1);
        expect_word(3'h7, 1'b1);
        check("ext1_x16", ext1_option_word, 15'h3abc);
        org_x16 = 1'b0;
        repeat (10) @(posedge ck);
        #1;
        ctrl_u.set_word(3'h1, 15'h4321, 1'b1);
        expect_word(3'h7, 1'b1);
        check("ext1_x8", ext1_option_word, 15'h4321);
        // reserved burst count, then a recovery field worked out from ns
        ctrl_u.set_word(3'h0, mk(3'h6) & 15'h7ff8, 1'b1);
        repeat (20) @(posedge clk);
        #1;
        check("count_rsvd", reserved_code_error, 1'b1);
        check("count_len8", burst_len8, 1'b0);
        rec_word = (mk(3'h6) & 15'h71ff) | {3'h0, ctrl_u.rec_code(STORE_RECOVERY_NS, CK_PERIOD_NS), 9'h000};
        ctrl_u.set_word(3'h0, rec_word, 1'b1);
        repeat (20) @(posedge clk);
        #1;
        check("rec_ns", recovery_clocks, 16'(REC_CLOCKS));
        check("rec_ok", reserved_code_error, 1'b0);
        stop_test();
    end
endmodule : mode_word_block_tb
